// ---- include/gtbca_pkg.sv ----
/*
  Package of the transmitter configuration and alarm block: register indices,
  address figures, gain limits and factory alarm settings.
  Assumes the register indices are those seen in the frames of the serial link.
*/
package gtbca_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned REG_W  = 16;
  localparam int unsigned ADDR_W = 8;

  // ==========================================================
  // Write register indices
  localparam logic [7:0] WR_NEW_SLAVE_ADDR = 8'h00;
  localparam logic [7:0] WR_GAIN_FACTOR    = 8'h01;
  localparam logic [7:0] WR_ALARM_THR1     = 8'h02;
  localparam logic [7:0] WR_ALARM_THR2     = 8'h03;
  localparam logic [7:0] WR_HYSTERESIS     = 8'h05;

  // ==========================================================
  // Read register indices
  localparam logic [7:0] RD_MEASURED_GAS   = 8'h04;
  localparam logic [7:0] RD_CURRENT_ADDR   = 8'h0a;

  // ==========================================================
  // Slave addressing
  localparam logic [7:0] ADDR_BUS_MIN      = 8'h01;
  localparam logic [7:0] ADDR_BUS_MAX      = 8'hf4;  // 244
  localparam logic [7:0] ADDR_DEFAULT      = 8'hf5;  // 245
  localparam logic [7:0] ADDR_SERVICE      = 8'hf6;  // 246
  localparam logic [7:0] ADDR_RANGE_STEP   = 8'h0f;  // 15 per jumper range

  // ==========================================================
  // Gain and scaling
  localparam logic [15:0] GAIN_UNITY       = 16'h2710; // 10.000
  localparam logic [15:0] GAIN_MAX         = 16'h7530; // 30.000
  localparam logic [15:0] NORM_FULL        = 16'h2710; // full measuring range

  // ==========================================================
  // Factory alarm settings in volume percent
  localparam int unsigned THR1_VOLPCT      = 19;
  localparam int unsigned THR2_VOLPCT      = 17;
  localparam int unsigned HYST_VOLPCT      = 1;
  localparam int unsigned RANGE_VOLPCT     = 25;
endpackage

// ---- logic/gtbca_core.sv ----
/*
  Slave-side configuration and alarm logic of a gas transmitter on a serial
  field bus: slave address selection, service select mode, gain scaling of the
  measured value, two alarm relays with hysteresis, and register access.
  Assumes a frame decoder on the same clock delivers register reads and writes
  already addressed to this slave, and the raw gas value on the same clock.
  Switch, jumper, mode and service cable levels come from pins.
*/
`timescale 1ns/1ps
module gtbca_core #(
  parameter int unsigned MEAS_RANGE_VOL = gtbca_pkg::RANGE_VOLPCT // Measuring range, vol. %
) (
  input  wire logic        clk,           // 40 MHz clock
  input  wire logic        reset,         // Synchronous, active high
  input  wire logic [3:0]  addr_switch,   // Rotary address switch pin
  input  wire logic [1:0]  range_jumper,  // Address range jumper pins
  input  wire logic        manual_mode,   // Pin: addressing by switch
  input  wire logic        service_sel,   // Pin: service_connector select
  input  wire logic [15:0] gas_raw,       // Unscaled normalised gas value
  input  wire logic [7:0]  frame_addr,    // Slave address of current frame
  input  wire logic        wr_en,         // Register write strobe
  input  wire logic [7:0]  wr_addr,       // Write register index
  input  wire logic [15:0] wr_data,       // Write data
  input  wire logic        rd_en,         // Register read strobe
  input  wire logic [7:0]  rd_addr,       // Read register index
  output logic      [15:0] rd_data,       // Read data
  output logic             rd_valid,      // Read answer pulse
  output logic             rd_err,        // Unmapped read pulse
  output logic             addr_hit,      // Frame addressed to this unit
  output logic      [7:0]  eff_addr,      // Address in use
  output logic             unit_active,   // Unit takes part on the bus
  output logic      [15:0] meas_value,    // Scaled measured value
  output logic             relay1,        // Alarm relay 1 energised
  output logic             relay2         // Alarm relay 2 energised
);
  import gtbca_pkg::*;

  // ==========================================================
  // Factory alarm settings in register units
  localparam logic [15:0] THR1_DEF = 16'(THR1_VOLPCT * 10000 / MEAS_RANGE_VOL);
  localparam logic [15:0] THR2_DEF = 16'(THR2_VOLPCT * 10000 / MEAS_RANGE_VOL);
  localparam logic [15:0] HYST_DEF = 16'(HYST_VOLPCT * 10000 / MEAS_RANGE_VOL);

  generate
    if (MEAS_RANGE_VOL <= THR1_VOLPCT || MEAS_RANGE_VOL > 10000) begin : g_bad_range
      $error("MEAS_RANGE_VOL cannot hold the factory thresholds");
    end
  endgenerate

  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0]  sw_s1;
    logic [3:0]  sw_s2;
    logic [1:0]  jp_s1;
    logic [1:0]  jp_s2;
    logic        sel_s1;
    logic        sel_s2;
    logic        man_s1;
    logic        man_s2;
    logic [7:0]  bus_addr;
    logic [15:0] gain;
    logic [15:0] thr1;
    logic [15:0] thr2;
    logic [15:0] hyst;
    logic [15:0] meas;
    logic        relay1;
    logic        relay2;
    logic [7:0]  eff_addr;
    logic        active;
    logic        addr_hit;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        rd_err;
  } gtbca_state_s;

  gtbca_state_s st;
  gtbca_state_s next_st;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] manual_addr(input logic [3:0] sw, input logic [1:0] jp);
    manual_addr = 8'(sw) + 8'(jp) * ADDR_RANGE_STEP;
  endfunction

  function automatic logic [15:0] clamp_range(input logic [15:0] v);
    clamp_range = (v > NORM_FULL) ? NORM_FULL : v;
  endfunction

  // Release level saturates at zero so a large hysteresis cannot wrap
  function automatic logic below_release(input logic [15:0] m, input logic [15:0] thr,
                                         input logic [15:0] hy);
    below_release = (thr > hy) && (m < thr - hy);
  endfunction

  logic [31:0] gain_prod;
  logic [31:0] gain_quot;
  logic        lo1;
  logic        lo2;

  always_comb begin
    next_st = st;
    // Pins pass two flops before use
    next_st.sw_s1  = addr_switch;
    next_st.sw_s2  = st.sw_s1;
    next_st.jp_s1  = range_jumper;
    next_st.jp_s2  = st.jp_s1;
    next_st.sel_s1 = service_sel;
    next_st.sel_s2 = st.sel_s1;
    next_st.man_s1 = manual_mode;
    next_st.man_s2 = st.man_s1;

    // Register writes
    if (wr_en) begin
      case (wr_addr)
        WR_NEW_SLAVE_ADDR: begin
          if (wr_data >= 16'(ADDR_BUS_MIN) && wr_data <= 16'(ADDR_BUS_MAX)) begin
            next_st.bus_addr = wr_data[7:0];
          end
        end
        WR_GAIN_FACTOR: begin
          next_st.gain = (wr_data > GAIN_MAX) ? GAIN_MAX : wr_data;
        end
        WR_ALARM_THR1: begin
          next_st.thr1 = clamp_range(wr_data);
        end
        WR_ALARM_THR2: begin
          next_st.thr2 = clamp_range(wr_data);
        end
        WR_HYSTERESIS: begin
          next_st.hyst = clamp_range(wr_data);
        end
        default: begin
          next_st.rd_err = st.rd_err;
        end
      endcase
    end

    // Scaling; the divider is wide but fits the slow update rate of the sensor
    gain_prod = 32'(gas_raw) * 32'(st.gain);
    gain_quot = gain_prod / 32'(GAIN_UNITY);
    next_st.meas = (gain_quot > 32'h0000ffff) ? 16'hffff : gain_quot[15:0];

    // Address selection: service cable overrides switch and stored address
    if (st.sel_s2) begin
      next_st.eff_addr = ADDR_SERVICE;
      next_st.active   = 1'b1;
    end else if (st.man_s2) begin
      next_st.eff_addr = manual_addr(st.sw_s2, st.jp_s2);
      next_st.active   = (st.sw_s2 != 4'h0);
    end else begin
      next_st.eff_addr = st.bus_addr;
      next_st.active   = 1'b1;
    end
    next_st.addr_hit = next_st.active && (frame_addr == next_st.eff_addr);

    // Relays with hysteresis
    lo1 = below_release(st.meas, st.thr1, st.hyst);
    lo2 = below_release(st.meas, st.thr2, st.hyst);
    if (st.meas > st.thr1) begin
      next_st.relay1 = 1'b1;
    end else if (lo1) begin
      next_st.relay1 = 1'b0;
    end
    if (st.meas > st.thr2) begin
      next_st.relay2 = 1'b1;
    end else if (lo2) begin
      next_st.relay2 = 1'b0;
    end

    // Register reads, answered one cycle later
    next_st.rd_valid = rd_en;
    next_st.rd_err   = 1'b0;
    next_st.rd_data  = 16'h0000;
    if (rd_en) begin
      case (rd_addr)
        RD_MEASURED_GAS: begin
          next_st.rd_data = st.meas;
        end
        RD_CURRENT_ADDR: begin
          next_st.rd_data = {8'h00, st.bus_addr};
        end
        default: begin
          next_st.rd_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st          <= '0;
      st.bus_addr <= ADDR_DEFAULT;
      st.gain     <= GAIN_UNITY;
      st.thr1     <= THR1_DEF;
      st.thr2     <= THR2_DEF;
      st.hyst     <= HYST_DEF;
      st.eff_addr <= ADDR_DEFAULT;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data     = st.rd_data;
  assign rd_valid    = st.rd_valid;
  assign rd_err      = st.rd_err;
  assign addr_hit    = st.addr_hit;
  assign eff_addr    = st.eff_addr;
  assign unit_active = st.active;
  assign meas_value  = st.meas;
  assign relay1      = st.relay1;
  assign relay2      = st.relay2;

  // ==========================================================
  // Checks
  property p_reset_defaults;
    @(posedge clk) disable iff (reset)
      $past(reset) |-> (st.bus_addr == ADDR_DEFAULT) && (st.thr1 == THR1_DEF) && (st.hyst == HYST_DEF);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("Defaults wrong after reset");

  property p_service_addr;
    @(posedge clk) disable iff (reset)
      st.sel_s2 |=> (eff_addr == ADDR_SERVICE) && unit_active;
  endproperty
  a_service_addr: assert property (p_service_addr) else $error("Service address not used");

  property p_select_only;
    @(posedge clk) disable iff (reset)
      (st.sel_s2 && frame_addr != ADDR_SERVICE) |=> !addr_hit;
  endproperty
  a_select_only: assert property (p_select_only) else $error("Other address answered in select mode");

  property p_read_addr;
    @(posedge clk) disable iff (reset)
      (rd_en && rd_addr == RD_CURRENT_ADDR) |=> rd_valid && rd_data == {8'h00, $past(st.bus_addr)};
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("Stored address not read back");

  property p_addr_write;
    @(posedge clk) disable iff (reset)
      (wr_en && wr_addr == WR_NEW_SLAVE_ADDR && wr_data >= 16'h0001 && wr_data <= 16'h00f4)
        |=> (st.bus_addr == $past(wr_data[7:0]))
            ##1 ($past(st.sel_s2) || $past(st.man_s2) || eff_addr == $past(st.bus_addr));
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("Address write not adopted");

  property p_addr_ignore;
    @(posedge clk) disable iff (reset)
      (wr_en && wr_addr == WR_NEW_SLAVE_ADDR && (wr_data == 16'h0000 || wr_data > 16'h00f4))
        |=> $stable(st.bus_addr);
  endproperty
  a_addr_ignore: assert property (p_addr_ignore) else $error("Bad address write stored");

  property p_gain_clamp;
    @(posedge clk) disable iff (reset)
      (wr_en && wr_addr == WR_GAIN_FACTOR && wr_data > GAIN_MAX) |=> st.gain == GAIN_MAX;
  endproperty
  a_gain_clamp: assert property (p_gain_clamp) else $error("Gain not clamped");

  property p_manual_zero;
    @(posedge clk) disable iff (reset)
      (st.man_s2 && !st.sel_s2 && st.sw_s2 == 4'h0) |=> !unit_active && !addr_hit;
  endproperty
  a_manual_zero: assert property (p_manual_zero) else $error("Switch zero not inactive");

  property p_relay_on;
    @(posedge clk) disable iff (reset)
      (st.meas > st.thr1) |=> relay1;
  endproperty
  a_relay_on: assert property (p_relay_on) else $error("Relay 1 not energised");

  property p_relay_hold;
    @(posedge clk) disable iff (reset)
      (relay2 && !lo2) |=> relay2;
  endproperty
  a_relay_hold: assert property (p_relay_hold) else $error("Relay 2 released early");

  property p_unity_gain;
    @(posedge clk) disable iff (reset)
      (st.gain == GAIN_UNITY && $stable(gas_raw)) |=> meas_value == $past(gas_raw);
  endproperty
  a_unity_gain: assert property (p_unity_gain) else $error("Unity gain changes value");
endmodule

// ---- tb/gtbca_master_model.sv ----
/*
  Bus master model: issues register writes and reads to the slave logic.
  Assumes the frame decoder has already matched the slave address.
*/
`timescale 1ns/1ps
module gtbca_master_model (
  input  wire logic        clk,     // Bus clock
  output logic             wr_en,   // Write strobe
  output logic [7:0]       wr_addr, // Write index
  output logic [15:0]      wr_data, // Write data
  output logic             rd_en,   // Read strobe
  output logic [7:0]       rd_addr, // Read index
  input  wire logic [15:0] rd_data, // Read answer
  input  wire logic        rd_valid,// Answer pulse
  input  wire logic        rd_err   // Unmapped pulse
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
    rd_addr = 8'h00;
  end
  // ==========================================================
  // One task at a time: sole master on the bus
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    // Released lines show garbage, not the old value
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic v, output logic e);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    #1;
    d = rd_data;
    v = rd_valid;
    e = rd_err;
  endtask
endmodule

// ---- tb/tb.sv ----
/*
  Testbench of the configuration and alarm logic: addressing, service select,
  gain scaling and relays. Assumes pins settle within four clocks.
*/
`timescale 1ns/1ps
module tb;
  import gtbca_pkg::*;
  localparam int T1 = THR1_VOLPCT * 10000 / RANGE_VOLPCT;
  localparam int T2 = THR2_VOLPCT * 10000 / RANGE_VOLPCT;
  localparam int HY = HYST_VOLPCT * 10000 / RANGE_VOLPCT;
  logic clk = 1'b0, reset = 1'b1, manual_mode = 1'b0, service_sel = 1'b0;
  logic [3:0] addr_switch = 4'h0;
  logic [1:0] range_jumper = 2'h0;
  logic [15:0] gas_raw = 16'h0000, wr_data, rd_data, meas_value, d;
  logic [7:0] frame_addr = 8'h00, wr_addr, rd_addr, eff_addr;
  logic wr_en, rd_en, rd_valid, rd_err, addr_hit, unit_active, relay1, relay2, v, e;
  int err_count = 0;
  int checked = 0;
  logic [7:0] wa [4] = '{8'h00, 8'hf5, 8'h01, 8'hf4};
  logic [7:0] ea [4] = '{8'hf5, 8'hf5, 8'h01, 8'hf4};
  always #12.5 clk = ~clk;
  gtbca_core dut (.clk(clk), .reset(reset), .addr_switch(addr_switch), .range_jumper(range_jumper),
    .manual_mode(manual_mode), .service_sel(service_sel), .gas_raw(gas_raw), .frame_addr(frame_addr),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err), .addr_hit(addr_hit), .eff_addr(eff_addr),
    .unit_active(unit_active), .meas_value(meas_value), .relay1(relay1), .relay2(relay2));
  gtbca_master_model m (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(25ns * 5000);
    err_count++;
    end_sim;
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    cyc(1);
    chk({8'h00, eff_addr}, 16'h00f5);
    m.read_reg(RD_CURRENT_ADDR, d, v, e);
    chk(d, 16'h00f5);
    chk({15'h0, v}, 16'h0001);
    chk({15'h0, e}, 16'h0000);
    m.read_reg(8'h07, d, v, e);
    chk({d[14:0], e}, 16'h0001);
    chk({15'h0, v}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      m.write_reg(WR_NEW_SLAVE_ADDR, {8'h00, wa[i]});
      cyc(2);
      chk({8'h00, eff_addr}, {8'h00, ea[i]});
    end
    @(posedge clk) frame_addr <= 8'hf4;
    cyc(2);
    chk({15'h0, addr_hit}, 16'h0001);
    @(posedge clk) service_sel <= 1'b1;
    cyc(4);
    chk({8'h00, eff_addr}, 16'h00f6);
    chk({15'h0, addr_hit}, 16'h0000);
    @(posedge clk) frame_addr <= 8'hf6;
    cyc(2);
    chk({15'h0, addr_hit}, 16'h0001);
    m.read_reg(RD_CURRENT_ADDR, d, v, e);
    chk(d, 16'h00f4);
    @(posedge clk) service_sel <= 1'b0;
    cyc(4);
    chk({7'h00, addr_hit, eff_addr}, 16'h00f4);
    @(posedge clk) manual_mode <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      for (int s = 1; s < 16; s += 14) begin
        @(posedge clk) begin
          addr_switch <= 4'(s);
          range_jumper <= 2'(j);
          frame_addr <= 8'(s + 15 * j);
        end
        cyc(4);
        chk({6'h00, unit_active, addr_hit, eff_addr}, 16'(768 + s + 15 * j));
      end
    end
    @(posedge clk) addr_switch <= 4'h0;
    cyc(4);
    chk({14'h0, unit_active, addr_hit}, 16'h0000);
    @(posedge clk) begin
      manual_mode <= 1'b0;
      gas_raw <= 16'h1388;
    end
    m.write_reg(WR_GAIN_FACTOR, GAIN_UNITY);
    cyc(2);
    m.read_reg(RD_MEASURED_GAS, d, v, e);
    chk(d, 16'h1388);
    m.write_reg(WR_GAIN_FACTOR, 16'h4e20);
    cyc(2);
    chk(meas_value, 16'h2710);
    m.write_reg(WR_GAIN_FACTOR, 16'h9c40);
    cyc(2);
    chk(meas_value, 16'h3a98);
    m.write_reg(WR_GAIN_FACTOR, GAIN_UNITY);
    @(posedge clk) gas_raw <= 16'(T1);
    cyc(3);
    chk({relay1, relay2}, 16'h0001);
    @(posedge clk) gas_raw <= 16'(T1 + 1);
    cyc(3);
    chk({relay1, relay2}, 16'h0003);
    @(posedge clk) gas_raw <= 16'(T1 - HY);
    cyc(3);
    chk({relay1, relay2}, 16'h0003);
    @(posedge clk) gas_raw <= 16'(T1 - HY - 1);
    cyc(3);
    chk({relay1, relay2}, 16'h0001);
    @(posedge clk) gas_raw <= 16'(T2 - HY - 1);
    cyc(3);
    chk({relay1, relay2}, 16'h0000);
    m.write_reg(WR_ALARM_THR1, 16'h0bb8);
    m.write_reg(WR_ALARM_THR2, 16'h07d0);
    m.write_reg(WR_HYSTERESIS, 16'h0064);
    @(posedge clk) gas_raw <= 16'h0bb9;
    cyc(3);
    chk({relay1, relay2}, 16'h0003);
    @(posedge clk) gas_raw <= 16'h0b53;
    cyc(3);
    chk({relay1, relay2}, 16'h0001);
    end_sim;
  end
endmodule
